// file: bench/sarc_host.sv
// host controller model: start strobe, selects, serial capture, slave clock
`include "sarc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sarc_host (
   input  wire logic              clk_i,
   input  wire logic              frame_i,
   input  wire logic              sclk_i,
   input  wire logic              sdo_i,
   output logic                   convert_start_n_o,
   output logic                   cs_n_o,
   output logic                   rd_n_o,
   output logic                   ext_sclk_o,
   output logic [`SARC_RES_W-1:0] rx_word_o,
   output logic [4:0]             rx_count_o
);
   logic sclk_prev;
   logic frame_prev;

   initial begin
      convert_start_n_o = 1'b1;
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      ext_sclk_o = 1'b0;
      rx_word_o = '0;
      rx_count_o = 5'h00;
      sclk_prev = 1'b0;
      frame_prev = 1'b0;
   end

   // master modes: a bit is taken on each rise of the device clock in the frame,
   // looked at on the falling system edge where the device outputs have settled
   always @(negedge clk_i) begin
      sclk_prev <= sclk_i;
      frame_prev <= frame_i;
      if (frame_i && !frame_prev) begin
         rx_count_o <= 5'h00;
      end else if (frame_i && sclk_i && !sclk_prev) begin
         rx_word_o <= {rx_word_o[`SARC_RES_W-2:0], sdo_i};
         rx_count_o <= rx_count_o + 5'h01;
      end
   end

   task automatic strobe(input logic lvl);
      convert_start_n_o = lvl;
   endtask

   // the caller holds select low until the transfer is over
   task automatic select(input logic cs_n, input logic rd_n);
      cs_n_o = cs_n;
      rd_n_o = rd_n;
   endtask

   // slave clock stands low between frames and only moves on falling system edges
   task automatic slave_read(output logic [`SARC_RES_W-1:0] w);
      w = '0;
      for (int i = 0; i < `SARC_RES_W; i++) begin
         repeat (4) @(negedge clk_i);
         w = {w[`SARC_RES_W-2:0], sdo_i};
         ext_sclk_o = 1'b1;
         repeat (4) @(negedge clk_i);
         ext_sclk_o = 1'b0;
      end
   endtask
endmodule

`default_nettype wire

// file: bench/sarc_top_bench.sv
// self-checking bench of the conversion read-out sequencer
`include "sarc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sarc_top_bench;
   localparam int W = `SARC_RES_W;
   logic         clk_i = 1'b0;
   logic         srst_i = 1'b1;
   logic         m_par = 1'b1;
   logic         m_mst = 1'b0;
   logic         m_dur = 1'b0;
   logic [1:0]   div = 2'h0;
   logic [W-1:0] sample = '0;
   logic         serial_data_in = 1'b0;
   logic         start_n, cs_n, rd_n, ext_sclk, busy, frame, sclk, sdo;
   logic         par_oe, frame_oe, sclk_oe, sdo_oe;
   logic [W-1:0] par_data, prev_par, rx_word;
   logic [4:0]   rx_count;
   int           per[4] = '{`SARC_PER_DIV0, `SARC_PER_DIV1, `SARC_PER_DIV2, `SARC_PER_DIV3};
   int           fail_count = 0;
   int           n_compared = 0;

   always #25 clk_i = ~clk_i;
   always @(negedge clk_i) prev_par <= par_data;

   sarc_top DUT (.clk_i(clk_i), .srst_i(srst_i), .convert_start_n_i(start_n), .cs_n_i(cs_n), .rd_n_i(rd_n),
      .mode_parallel_i(m_par), .mode_master_i(m_mst), .mode_read_during_i(m_dur),
      .serial_clock_divider_i(div), .ext_sclk_i(ext_sclk), .serial_data_in_i(serial_data_in), .sample_i(sample),
      .busy_o(busy), .par_data_o(par_data), .par_data_oe_o(par_oe), .frame_o(frame), .frame_oe_o(frame_oe),
      .sclk_o(sclk), .sclk_oe_o(sclk_oe), .serial_data_out_o(sdo), .serial_data_out_oe_o(sdo_oe));

   sarc_host u_host (.clk_i(clk_i), .frame_i(frame), .sclk_i(sclk), .sdo_i(sdo), .convert_start_n_o(start_n),
      .cs_n_o(cs_n), .rd_n_o(rd_n), .ext_sclk_o(ext_sclk), .rx_word_o(rx_word), .rx_count_o(rx_count));

   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [W-1:0] got, input logic [W-1:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_range(input int got, input int lo, input int hi, input string what);
      n_compared++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("MISMATCH at %0t: %s took %0d, want %0d..%0d", $time, what, got, lo, hi);
      end
   endtask

   function automatic logic probe(input int s);
      case (s)
         0: return busy;
         1: return frame;
         2: return par_oe;
         default: return sdo_oe;
      endcase
   endfunction

   // bounded wait, counted in cycles at the falling edge
   task automatic wait_for(input int s, input logic lvl, output int n);
      n = 0;
      while (probe(s) !== lvl && n < 1000) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 1000) begin
         fail_count++;
         $display("MISMATCH at %0t: wait on %0d timed out", $time, s);
         close_out();
      end
   endtask

   task automatic conv(output int rise);
      u_host.strobe(1'b0);
      wait_for(0, 1'b1, rise);
      u_host.strobe(1'b1);
   endtask

   task automatic par_test();
      int rise, n;
      for (int k = 0; k < 2; k++) begin
         sample = k ? 18'h2A5C3 : 18'h1B6E4;
         conv(rise);
         chk_range(rise, 1, 5, "busy rise");
         wait_for(0, 1'b0, n);
         chk_range(n, 20, `SARC_BUSY_MAX_CYC, "busy width");
         chk_range(rise + n - 1, 20, `SARC_BUSY_MAX_CYC, "start to data");
         chk_word(prev_par, sample, "data before busy fall");
         chk_word(par_data, sample, "own result");
         u_host.select(1'b0, 1'b0);
         wait_for(2, 1'b1, n);
         chk_range(n, 1, 4, "bus access");
         chk_word(par_data, sample, "bus word");
         u_host.select(1'b1, 1'b1);
         wait_for(2, 1'b0, n);
      end
      $display("parallel test done");
   endtask

   task automatic after_test();
      int rise, n, f;
      m_par = 1'b0;
      m_mst = 1'b1;
      for (int d = 0; d < 4; d++) begin
         div = 2'(d);
         sample = 18'h30F0F ^ W'(d << 4);
         u_host.select(1'b0, 1'b1);
         wait_for(3, 1'b1, n);
         chk_range(n, 1, 4, "select to drive");
         conv(rise);
         wait_for(1, 1'b1, f);
         chk_range(rise + f, 25, 36, "frame after end");
         chk_word(W'({frame_oe, sclk_oe, sdo_oe}), W'(3'h7), "serial drive");
         wait_for(1, 1'b0, f);
         chk_range(f, 18 * per[d], 18 * per[d] + 1, "frame width");
         wait_for(0, 1'b0, n);
         chk_range(n, 1, 2, "busy after frame");
         chk_word(rx_word, sample, "serial word");
         chk_word(W'(rx_count), W'(18), "bit count");
         u_host.select(1'b1, 1'b1);
         repeat (4) @(negedge clk_i);
         chk_word(W'({frame_oe, sclk_oe, sdo_oe}), W'(0), "serial release");
      end
      $display("master read-after test done");
   endtask

   task automatic during_test();
      int rise, f, n;
      logic [W-1:0] last;
      m_dur = 1'b1;
      div = 2'h0;
      u_host.select(1'b0, 1'b1);
      for (int k = 0; k < 2; k++) begin
         last = sample;
         sample = k ? 18'h0C3A5 : 18'h35A5A;
         conv(rise);
         wait_for(1, 1'b1, f);
         chk_range(rise + f, 10, 15, "frame in conversion");
         wait_for(1, 1'b0, f);
         chk_range(f, 18 * per[0], 18 * per[0] + 1, "fast clock");
         chk_word(rx_word, last, "previous word");
         wait_for(0, 1'b0, n);
      end
      u_host.select(1'b1, 1'b1);
      $display("master read-during test done");
   endtask

   task automatic slave_test();
      int n;
      logic [W-1:0] w;
      m_mst = 1'b0;
      m_dur = 1'b0;
      sample = 18'h2F00D;
      conv(n);
      wait_for(0, 1'b0, n);
      u_host.select(1'b0, 1'b1);
      serial_data_in = 1'b1;
      repeat (4) @(negedge clk_i);
      u_host.slave_read(w);
      @(negedge clk_i);
      chk_word(w, sample, "slave word");
      u_host.slave_read(w);
      chk_word(w, 18'h3FFFF, "chained word");
      u_host.select(1'b1, 1'b1);
      $display("slave test done");
   endtask

   initial begin
      repeat (12) @(negedge clk_i);
      srst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      par_test();
      after_test();
      during_test();
      slave_test();
      close_out();
   end
endmodule

`default_nettype wire

// file: design/sarc_fifo.sv
// result fifo with a registered read stage
`timescale 1ns/1ps
`default_nettype none

module sarc_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wptr_q;
   logic [AW-1:0]    rptr_q;
   logic [AW:0]      cnt_q;
   logic             ovalid_q;
   logic [WIDTH-1:0] odata_q;
   wire              push_w  = in_valid_i & in_ready_o;
   wire              fill_w  = (cnt_q != '0) & (~ovalid_q | out_ready_i);
   wire              drain_w = ovalid_q & out_ready_i;

   assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = ovalid_q;
   assign out_data_o  = odata_q;

   always_ff @(posedge clk_i) begin
      if (push_w) begin
         mem_q[wptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wptr_q   <= '0;
         rptr_q   <= '0;
         cnt_q    <= '0;
         ovalid_q <= 1'b0;
         odata_q  <= '0;
      end else begin
         if (push_w) begin
            wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
         end
         if (fill_w) begin
            rptr_q  <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
            odata_q <= mem_q[rptr_q];
         end
         cnt_q    <= cnt_q + (AW+1)'(push_w) - (AW+1)'(fill_w);
         ovalid_q <= fill_w | (ovalid_q & ~drain_w);
      end
   end
endmodule

`default_nettype wire

// file: design/sarc_top.sv
// conversion handshake and result read-out sequencer
//
// Overview of operation
// RULE1 - busy rises promptly after start strobe falls
// RULE2 - busy at most 1.5 us per conversion
// RULE3 - busy drops at least 10 ns after end
// RULE4 - parallel result valid within 1.5 us
// RULE5 - result valid 20 ns before busy falls
// RULE6 - parallel data driven soon after bus request
// RULE7 - every result is an 18-bit word
// RULE8 - result offered is that conversion's own
// RULE9 - master serial outputs driven after chip select
// RULE10 - serial outputs released when chip select rises
// RULE11 - read-after mode: frame once conversion completes
// RULE12 - read-after mode: busy ends after frame
// RULE13 - read-during mode: frame 525 ns after start
// RULE14 - read-during mode: fast internal serial clock - code uses the divider-chosen period in this mode too
// RULE15 - slave mode: shift on external clock edge
// RULE16 - divider picks clock rate, busy stretches
// RULE17 - host waits busy, holds select through transfer
`include "sarc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sarc_top (
   input  wire logic                   clk_i,
   input  wire logic                   srst_i,
   input  wire logic                   convert_start_n_i,
   input  wire logic                   cs_n_i,
   input  wire logic                   rd_n_i,
   input  wire logic                   mode_parallel_i,
   input  wire logic                   mode_master_i,
   input  wire logic                   mode_read_during_i,
   input  wire logic [1:0]             serial_clock_divider_i,
   input  wire logic                   ext_sclk_i,
   input  wire logic                   serial_data_in_i,
   input  wire logic [`SARC_RES_W-1:0] sample_i,
   output logic                        busy_o,
   output logic [`SARC_RES_W-1:0]      par_data_o,
   output logic                        par_data_oe_o,
   output logic                        frame_o,
   output logic                        frame_oe_o,
   output logic                        sclk_o,
   output logic                        sclk_oe_o,
   output logic                        serial_data_out_o,
   output logic                        serial_data_out_oe_o
);
   // every pin except sample_i and srst_i passes two flops before logic reads it
   logic [7:0]               pin_s1_q;
   logic [7:0]               pin_s2_q;
   logic                     cnv_s3_q;
   logic                     sck_s3_q;
   sarc_pkg::sarc_state_t    state_q;
   logic [4:0]               cnt_q;
   logic [`SARC_RES_W-1:0]   par_q;
   logic [`SARC_RES_W-1:0]   shift_q;
   logic                     xfer_q;
   logic [2:0]               phase_q;
   logic [4:0]               bits_q;
   logic                     sclk_q;
   logic [5:0]               busy_cnt_q;
   logic                     fifo_in_ready;
   logic                     fifo_out_valid;
   logic [`SARC_RES_W-1:0]   fifo_out_data;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pin_s1_q <= 8'hE1;
         pin_s2_q <= 8'hE1;
         cnv_s3_q <= 1'b1;
         sck_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= {cs_n_i, rd_n_i, convert_start_n_i, ext_sclk_i, serial_data_in_i,
                      mode_parallel_i, mode_master_i, mode_read_during_i};
         pin_s2_q <= pin_s1_q;
         cnv_s3_q <= pin_s2_q[5];
         sck_s3_q <= pin_s2_q[4];
      end
   end

   logic [1:0] div_s1_q;
   logic [1:0] div_s2_q;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         div_s1_q <= 2'h0;
         div_s2_q <= 2'h0;
      end else begin
         div_s1_q <= serial_clock_divider_i;
         div_s2_q <= div_s1_q;
      end
   end

   wire cs_n_w   = pin_s2_q[7];
   wire rd_n_w   = pin_s2_q[6];
   wire cnv_n_w  = pin_s2_q[5];
   wire sck_w    = pin_s2_q[4];
   wire serial_data_in_w   = pin_s2_q[3];
   wire par_w    = pin_s2_q[2];
   wire mst_w    = pin_s2_q[1];
   wire dur_w    = pin_s2_q[0];

   wire sarc_pkg::sarc_mode_t mode_w = par_w ? sarc_pkg::MD_PAR :
                                       !mst_w ? sarc_pkg::MD_SLAVE :
                                       dur_w ? sarc_pkg::MD_M_DURING : sarc_pkg::MD_M_AFTER;
   wire master_w = (mode_w == sarc_pkg::MD_M_AFTER) | (mode_w == sarc_pkg::MD_M_DURING);
   wire slave_w  = (mode_w == sarc_pkg::MD_SLAVE);

   // a strobe while busy or while the fifo is full is ignored
   wire idle_w     = (state_q == sarc_pkg::ST_IDLE);
   wire start_w    = cnv_s3_q & ~cnv_n_w & idle_w & fifo_in_ready; // see RULE17
   wire conv_end_w = (state_q == sarc_pkg::ST_CONV) & (cnt_q == 5'(`SARC_CONV_CYC - 1));
   wire during_go  = (state_q == sarc_pkg::ST_CONV) & (mode_w == sarc_pkg::MD_M_DURING)
                     & (cnt_q == 5'(`SARC_DURING_CYC - 1)) & ~xfer_q; // see RULE13
   // waiting for a read-during frame here would stretch busy past its limit
   wire load_ok_w  = (state_q == sarc_pkg::ST_LOAD) & fifo_out_valid;
   wire after_go   = load_ok_w & (mode_w == sarc_pkg::MD_M_AFTER); // see RULE11
   // read-during frames take the held word at frame start, so a load never cuts a frame
   wire ld_shift_w = load_ok_w & (mode_w != sarc_pkg::MD_M_DURING);

   // serial clock period in system cycles, chosen by the divider
   wire [2:0] per_w  = (div_s2_q == 2'h0) ? `SARC_PER_DIV0 :
                       (div_s2_q == 2'h1) ? `SARC_PER_DIV1 :
                       (div_s2_q == 2'h2) ? `SARC_PER_DIV2 : `SARC_PER_DIV3; // see RULE14 see RULE16
   wire       wrap_w = xfer_q & (phase_q == per_w - 3'h1);
   wire       last_w = wrap_w & (bits_q == 5'(`SARC_RES_W - 1));
   wire       sck_rise_w = sck_w & ~sck_s3_q & slave_w & ~cs_n_w;

   sarc_fifo #(
      .WIDTH (`SARC_RES_W),
      .DEPTH (`SARC_FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .in_valid_i  (conv_end_w),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (sample_i),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (load_ok_w),
      .out_data_o  (fifo_out_data)
   );

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_q <= sarc_pkg::ST_IDLE;
         cnt_q   <= 5'h00;
      end else begin
         case (state_q)
            sarc_pkg::ST_IDLE: begin
               cnt_q <= 5'h00;
               if (start_w) begin
                  state_q <= sarc_pkg::ST_CONV; // see RULE1
               end
            end
            sarc_pkg::ST_CONV: begin
               cnt_q <= cnt_q + 5'h01;
               if (conv_end_w) begin
                  state_q <= sarc_pkg::ST_LOAD;
               end
            end
            sarc_pkg::ST_LOAD: begin
               if (after_go) begin
                  state_q <= sarc_pkg::ST_XFER;
               end else if (load_ok_w) begin
                  state_q <= sarc_pkg::ST_HOLD;
               end
            end
            sarc_pkg::ST_HOLD: begin
               state_q <= sarc_pkg::ST_IDLE; // see RULE3 see RULE5
            end
            sarc_pkg::ST_XFER: begin
               if (last_w) begin
                  state_q <= sarc_pkg::ST_TAIL;
               end
            end
            sarc_pkg::ST_TAIL: begin
               state_q <= sarc_pkg::ST_IDLE; // see RULE12
            end
            default: begin
               state_q <= sarc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // result word moves from the fifo straight to par_q; read-during frames shift out the older word held in par_q
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         par_q   <= 18'h00000;
         shift_q <= 18'h00000;
      end else begin
         if (load_ok_w) begin
            par_q   <= fifo_out_data; // see RULE4 see RULE7 see RULE8
         end
         if (ld_shift_w) begin
            shift_q <= fifo_out_data; // see RULE7
         end else if (during_go) begin
            shift_q <= par_q; // see RULE13
         end else if (wrap_w) begin
            shift_q <= {shift_q[`SARC_RES_W-2:0], 1'b0};
         end else if (sck_rise_w) begin
            shift_q <= {shift_q[`SARC_RES_W-2:0], serial_data_in_w}; // see RULE15
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         xfer_q  <= 1'b0;
         phase_q <= 3'h0;
         bits_q  <= 5'h00;
         sclk_q  <= 1'b0;
      end else begin
         if (during_go | after_go) begin
            xfer_q  <= 1'b1;
            phase_q <= 3'h0;
            bits_q  <= 5'h00;
         end else if (last_w) begin
            xfer_q <= 1'b0;
         end else if (xfer_q) begin
            phase_q <= wrap_w ? 3'h0 : phase_q + 3'h1;
            bits_q  <= wrap_w ? bits_q + 5'h01 : bits_q;
         end
         // rising edge mid-bit leaves setup and hold around it
         sclk_q <= xfer_q & ~last_w & ((phase_q + 3'h1) >= (per_w >> 1)) & ~wrap_w;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         busy_cnt_q <= 6'h00;
      end else begin
         busy_cnt_q <= idle_w ? 6'h00 : ((busy_cnt_q == 6'h3F) ? busy_cnt_q : busy_cnt_q + 6'h01);
      end
   end

   assign busy_o               = ~idle_w; // see RULE2
   assign par_data_o           = par_q;
   assign par_data_oe_o        = (mode_w == sarc_pkg::MD_PAR) & ~cs_n_w & ~rd_n_w; // see RULE6
   assign frame_o              = xfer_q;
   assign sclk_o               = sclk_q;
   assign serial_data_out_o    = shift_q[`SARC_RES_W-1];
   assign frame_oe_o           = master_w & ~cs_n_w; // see RULE9 see RULE10
   assign sclk_oe_o            = master_w & ~cs_n_w;
   assign serial_data_out_oe_o = (master_w | slave_w) & ~cs_n_w;

   busy_rise_a: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE1
      start_w |=> busy_o)
      else $error("busy did not rise after start");

   busy_width_a: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE2
      (busy_o && mode_w != sarc_pkg::MD_M_AFTER) |-> busy_cnt_q < 6'(`SARC_BUSY_MAX_CYC))
      else $error("busy held too long");

   eoc_gap_a: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE3
      conv_end_w |=> busy_o ##1 busy_o)
      else $error("busy fell too soon after conversion end");

   data_fresh_a: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE8
      load_ok_w |=> par_q == $past(fifo_out_data))
      else $error("parallel data not the new result");

   data_first_a: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE5
      ($fell(busy_o) && mode_w == sarc_pkg::MD_PAR) |-> $past(state_q, 2) == sarc_pkg::ST_LOAD)
      else $error("busy fell without data settled");

   release_sel_a: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE10
      cs_n_w |-> !frame_oe_o && !sclk_oe_o && !serial_data_out_oe_o)
      else $error("serial pins driven with chip select high");

   tail_busy_a: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE12
      ($fell(xfer_q) && state_q == sarc_pkg::ST_TAIL) |-> busy_o ##1 !busy_o)
      else $error("busy did not end one cycle after frame");

   word_len_a: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE7
      $fell(xfer_q) |-> $past(bits_q) == 5'd17)
      else $error("frame did not carry 18 bits");

   during_frame_a: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE13
      (start_w && mode_w == sarc_pkg::MD_M_DURING && !xfer_q) |-> ##11 xfer_q)
      else $error("read-during frame late");

   slave_shift_a: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE15
      (sck_rise_w && !load_ok_w && !wrap_w) |=> serial_data_out_o == $past(shift_q[16]))
      else $error("slave bit not shifted");

endmodule

`default_nettype wire

// file: shared/sarc_defines.svh
// timing counts and field widths of the converter read-out block
`ifndef SARC_DEFINES_SVH
`define SARC_DEFINES_SVH

`define SARC_CLK_NS         50
`define SARC_RES_W          18
`define SARC_FIFO_DEPTH     8
`define SARC_BUSY_RISE_NS   35
`define SARC_BUSY_RISE_CYC  (((`SARC_BUSY_RISE_NS / `SARC_CLK_NS) < 1) ? 1 : (`SARC_BUSY_RISE_NS / `SARC_CLK_NS))
`define SARC_BUSY_MAX_NS    1500
`define SARC_BUSY_MAX_CYC   (`SARC_BUSY_MAX_NS / `SARC_CLK_NS)
`define SARC_CONV_NS        1500
`define SARC_CONV_CYC       ((`SARC_CONV_NS / `SARC_CLK_NS) - 5)
`define SARC_EOC_BUSY_NS    10
`define SARC_EOC_BUSY_CYC   ((`SARC_EOC_BUSY_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_DURING_NS      525
`define SARC_DURING_CYC     (`SARC_DURING_NS / `SARC_CLK_NS)
`define SARC_TAIL_NS        25
`define SARC_TAIL_CYC       ((`SARC_TAIL_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_PER_DIV0       3'h2
`define SARC_PER_DIV1       3'h2
`define SARC_PER_DIV2       3'h3
`define SARC_PER_DIV3       3'h6

`endif

// file: shared/sarc_pkg.sv
// types of the converter read-out block
package sarc_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CONV = 3'b001,
      ST_LOAD = 3'b010,
      ST_HOLD = 3'b011,
      ST_XFER = 3'b100,
      ST_TAIL = 3'b101
   } sarc_state_t;

   typedef enum logic [1:0] {
      MD_PAR      = 2'b00,
      MD_SLAVE    = 2'b01,
      MD_M_AFTER  = 2'b10,
      MD_M_DURING = 2'b11
   } sarc_mode_t;

endpackage
